// file: rtl/srx_pkg.sv
package srx_pkg;
  typedef enum logic [1:0] {srx_custom, srx_sonet, srx_xaui,
                            srx_gigabit_ethernet_mode} srx_proto_type;
  typedef enum logic [2:0] {srx_bitslip, srx_pat16, srx_pat10,
                            srx_xaui_align, srx_gigabit_ethernet_mode_align} srx_align_type;
  typedef enum logic [1:0] {srx_los, srx_detect, srx_synced} srx_sync_type;

  typedef struct packed {
    logic data_locked;
    logic pll_locked_n;
    logic vco_track_data;
    logic pll_pd;
    logic cru_pd;
  } srx_cru_type;

  typedef struct packed {
    logic [9:0] data;
    logic       valid;
    logic       aligned;
    logic       pat_det;
    logic       run_err;
  } srx_word_type;

  localparam srx_cru_type SRX_CRU_RESET = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  localparam logic [10:0] SRX_PPM_125   = 11'h07d;
  localparam logic [10:0] SRX_PPM_250   = 11'h0fa;
  localparam logic [10:0] SRX_PPM_500   = 11'h1f4;
  localparam logic [10:0] SRX_PPM_1000  = 11'h3e8;
  // Phase error in hundredths of a UI
  localparam logic [6:0]  SRX_PHASE_LIM = 7'h08;
  localparam logic [9:0]  SRX_COMMA_NEG = 10'h17c;
  localparam logic [9:0]  SRX_COMMA_POS = 10'h283;
  localparam int          SRX_RUN_STEP10 = 5;
  localparam int          SRX_RUN_MAX10  = 160;
  localparam int          SRX_RUN_STEP8  = 4;
  localparam int          SRX_RUN_MAX8   = 128;
  localparam logic [3:0]  SRX_LAST10 = 4'h9;
  localparam logic [3:0]  SRX_LAST8  = 4'h7;
  localparam int          SRX_SLICE_W = 32;
  localparam int          SRX_HIST_W  = 42;
  localparam logic [1:0]  SRX_COMMAS_LAST = 2'h2;
  localparam logic [1:0]  SRX_ERR_LAST    = 2'h3;
  localparam logic [1:0]  SRX_GOOD_LAST   = 2'h3;
  localparam logic [3:0]  SRX_WEIGHT_MIN  = 4'h4;
  localparam logic [3:0]  SRX_WEIGHT_MAX  = 4'h6;

  function automatic logic [10:0] srx_ppm_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    return SRX_PPM_125;
      2'h1:    return SRX_PPM_250;
      2'h2:    return SRX_PPM_500;
      default: return SRX_PPM_1000;
    endcase
  endfunction

  // Disparity weight check stands in for a full code-group decode
  function automatic logic srx_weight_ok(input logic [9:0] w);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 10; i++) begin
      n = n + {3'h0, w[i]};
    end
    return (n >= SRX_WEIGHT_MIN) && (n <= SRX_WEIGHT_MAX);
  endfunction
endpackage

// file: rtl/srx_top.sv
`timescale 1ns/1ps
`default_nettype none
module srx_top #(
  parameter srx_pkg::srx_proto_type PROTOCOL   = srx_pkg::srx_custom,
  parameter srx_pkg::srx_align_type ALIGN_MODE = srx_pkg::srx_bitslip,
  parameter bit                     WIDTH10    = 1'b1,
  parameter bit                     OVERRIDE_USED = 1'b0,
  parameter logic [1:0]             PPM_SEL    = 2'h0,
  parameter int                     RUN_LIMIT  = 160,
  parameter logic [31:0]            PATTERN    = 32'h0000017c,
  parameter bit                     FOUR_BYTE  = 1'b0,
  parameter bit                     MATCH_LOW7 = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 chan_used,
  input  wire logic                 force_data_lock,
  input  wire logic                 force_ref_lock,
  input  wire logic                 pll_lock_raw,
  input  wire logic [10:0]          ppm_diff,
  input  wire logic [6:0]           phase_err,
  output srx_pkg::srx_cru_type      cru_stat,
  input  wire logic                 rx_clk,
  input  wire logic                 serial_in,
  input  wire logic                 slip_req,
  input  wire logic                 realign_req,
  input  wire logic                 align_enable,
  output srx_pkg::srx_word_type     word_out,
  output logic                      cfg_error
);
  import srx_pkg::*;

  localparam logic [3:0] W_LAST = WIDTH10 ? SRX_LAST10 : SRX_LAST8;
  localparam logic [7:0] RUN_LIM = 8'(RUN_LIMIT);
  localparam bit CUST_SON = (PROTOCOL == srx_custom) ||
                            (PROTOCOL == srx_sonet);
  localparam bit MODE_OK =
    (ALIGN_MODE == srx_bitslip) ? CUST_SON :
    // 8-bit path only; four-byte in SONET only
    (ALIGN_MODE == srx_pat16) ? (CUST_SON && !WIDTH10 &&
                                 (!FOUR_BYTE || PROTOCOL == srx_sonet)) :
    (ALIGN_MODE == srx_pat10) ? (PROTOCOL == srx_custom && WIDTH10) :
    (ALIGN_MODE == srx_xaui_align) ? (PROTOCOL == srx_xaui && WIDTH10) :
    (PROTOCOL == srx_gigabit_ethernet_mode && WIDTH10);
  localparam bit RUN_OK = WIDTH10 ?
    (RUN_LIMIT >= SRX_RUN_STEP10 && RUN_LIMIT <= SRX_RUN_MAX10 &&
     RUN_LIMIT % SRX_RUN_STEP10 == 0) :
    (RUN_LIMIT >= SRX_RUN_STEP8 && RUN_LIMIT <= SRX_RUN_MAX8 &&
     RUN_LIMIT % SRX_RUN_STEP8 == 0);
  localparam bit CFG_OK = MODE_OK && RUN_OK;

  // A refused configuration keeps the aligner idle rather than guessing
  assign cfg_error = !CFG_OK;

  logic pll_s1;
  logic pll_s2;
  logic ovr_data;
  logic ovr_ref;
  logic match_ok;
  logic auto_data;
  logic next_track;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
    end else begin
      pll_s1 <= pll_lock_raw;
      pll_s2 <= pll_s1;
    end
  end

  assign ovr_data = OVERRIDE_USED && force_data_lock;
  assign ovr_ref  = OVERRIDE_USED && !force_data_lock && force_ref_lock;
  // ppm and phase window; static threshold
  assign match_ok = (ppm_diff <= srx_ppm_limit(PPM_SEL)) &&
                    (phase_err <= SRX_PHASE_LIM);

  // automatic switchover, drops back on frequency loss
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_data <= 1'b0;
    end else if (!chan_used) begin
      auto_data <= 1'b0;
    end else if (!auto_data && match_ok) begin
      auto_data <= 1'b1;
    end else if (auto_data && ppm_diff > srx_ppm_limit(PPM_SEL)) begin
      auto_data <= 1'b0;
    end
  end

  always_comb begin
    next_track = auto_data;
    if (!chan_used) begin
      next_track = 1'b0;
    end else if (ovr_data) begin
      next_track = 1'b1;
    end else if (ovr_ref) begin
      next_track = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cru_stat <= SRX_CRU_RESET;
    end else begin
      cru_stat.vco_track_data <= next_track;
      cru_stat.data_locked    <= next_track;
      cru_stat.pll_locked_n   <= !(pll_s2 && chan_used);
      cru_stat.pll_pd         <= !chan_used;
      cru_stat.cru_pd         <= !chan_used;
    end
  end

  // Link side: recovered clock domain
  logic                  lr1;
  logic                  lrst_n;
  logic                  lk1;
  logic                  lk2;
  logic                  active;
  logic [SRX_HIST_W-1:0] hist;
  logic [3:0]            bit_cnt;
  logic [3:0]            off;
  logic                  slip_d;
  logic                  realign_d;
  logic                  slip_rise;
  logic                  realign_rise;
  logic [SRX_SLICE_W-1:0] head;
  logic [SRX_SLICE_W-1:0] cur;
  logic                  head_hit;
  logic                  cur_hit;
  logic                  realign_now;
  logic                  strobe;
  logic                  locked;
  logic [7:0]            run_cnt;
  logic                  run_now;
  logic                  run_flag;
  srx_sync_type          sync_st;
  logic [1:0]            comma_cnt;
  logic [1:0]            sync_err;
  logic [1:0]            sync_good;
  logic                  word_ok;

  // Release of reset is retimed so the link side leaves reset cleanly
  always_ff @(posedge rx_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr1    <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lr1    <= 1'b1;
      lrst_n <= lr1;
    end
  end

  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lk1 <= 1'b0;
      lk2 <= 1'b0;
    end else begin
      lk1 <= cru_stat.data_locked;
      lk2 <= lk1;
    end
  end

  assign active = lk2 && CFG_OK;

  function automatic logic pat_hit(input logic [SRX_SLICE_W-1:0] s);
    logic [9:0] p;
    p = PATTERN[9:0];
    case (ALIGN_MODE)
      srx_pat16:
        return FOUR_BYTE ? (s == PATTERN) : (s[15:0] == PATTERN[15:0]);
      srx_pat10: begin
        // full or low-seven compare; both disparities
        if (MATCH_LOW7) begin
          return (s[6:0] == p[6:0]) || (s[6:0] == ~p[6:0]);
        end
        return (s[9:0] == p) || (s[9:0] == ~p);
      end
      srx_bitslip:
        return WIDTH10 ? (s[9:0] == p) : (s[7:0] == p[7:0]);
      default:
        return (s[9:0] == SRX_COMMA_NEG) || (s[9:0] == SRX_COMMA_POS);
    endcase
  endfunction

  // oldest bit at index 0, so the first bit lands in the LSB
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      hist <= '0;
    end else begin
      hist <= {serial_in, hist[SRX_HIST_W-1:1]};
    end
  end

  assign head     = hist[SRX_SLICE_W-1:0];
  assign cur      = hist[off +: SRX_SLICE_W];
  assign head_hit = pat_hit(head);
  assign cur_hit  = pat_hit(cur);

  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      slip_d    <= 1'b0;
      realign_d <= 1'b0;
    end else begin
      slip_d    <= slip_req;
      realign_d <= realign_req;
    end
  end

  assign slip_rise    = slip_req && !slip_d;
  assign realign_rise = realign_req && !realign_d;

  // Pattern alignment restarts word framing on the pattern's first bit
  always_comb begin
    realign_now = 1'b0;
    if (active) begin
      case (ALIGN_MODE)
        srx_pat16:      realign_now = !locked && head_hit;
        // only while user enable is high
        srx_pat10:      realign_now = align_enable && head_hit;
        srx_xaui_align: realign_now = (sync_st == srx_los) && head_hit;
        srx_gigabit_ethernet_mode_align: realign_now = (sync_st == srx_los) && head_hit;
        default:        realign_now = 1'b0;
      endcase
    end
  end

  assign strobe = active && (realign_now || bit_cnt == W_LAST);

  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_cnt <= 4'h0;
    end else if (!active || strobe) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // barrel offset steps one bit per request, wraps at word width
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      off <= 4'h0;
    end else if (ALIGN_MODE == srx_bitslip && active && slip_rise) begin
      off <= (off == W_LAST) ? 4'h0 : off + 4'h1;
    end
  end

  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      locked <= 1'b0;
    end else if (!active) begin
      locked <= 1'b0;
    end else if (realign_now) begin
      locked <= 1'b1;
    // user request drops lock and searches again
    end else if (ALIGN_MODE == srx_pat16 && realign_rise) begin
      locked <= 1'b0;
    end else if (ALIGN_MODE == srx_bitslip && strobe && cur_hit) begin
      locked <= 1'b1;
    end
  end

  // consecutive equal bits against the limit
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      run_cnt <= 8'h01;
    end else if (serial_in == hist[SRX_HIST_W-1]) begin
      run_cnt <= (run_cnt == 8'hff) ? run_cnt : run_cnt + 8'h01;
    end else begin
      run_cnt <= 8'h01;
    end
  end

  assign run_now = run_cnt > RUN_LIM;

  // Violation between words is held until the next word; set beats clear
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      run_flag <= 1'b0;
    end else begin
      run_flag <= run_now || (run_flag && !strobe);
    end
  end

  assign word_ok = srx_weight_ok(cur[9:0]);

  // loss, comma detect, synced with error count and recovery
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sync_st   <= srx_los;
      comma_cnt <= 2'h0;
      sync_err  <= 2'h0;
      sync_good <= 2'h0;
    end else if (!active || (ALIGN_MODE != srx_xaui_align &&
                             ALIGN_MODE != srx_gigabit_ethernet_mode_align)) begin
      sync_st   <= srx_los;
      comma_cnt <= 2'h0;
    end else if (strobe) begin
      case (sync_st)
        srx_los: begin
          if (realign_now) begin
            sync_st   <= srx_detect;
            comma_cnt <= 2'h0;
          end
        end
        srx_detect: begin
          if (!word_ok) begin
            sync_st <= srx_los;
          end else if (cur_hit && comma_cnt == SRX_COMMAS_LAST - 2'h1) begin
            sync_st   <= srx_synced;
            sync_err  <= 2'h0;
            sync_good <= 2'h0;
          end else if (cur_hit) begin
            comma_cnt <= comma_cnt + 2'h1;
          end
        end
        srx_synced: begin
          if (!word_ok) begin
            sync_good <= 2'h0;
            if (sync_err == SRX_ERR_LAST) begin
              sync_st <= srx_los;
            end else begin
              sync_err <= sync_err + 2'h1;
            end
          end else if (sync_good == SRX_GOOD_LAST && sync_err != 2'h0) begin
            sync_err  <= sync_err - 2'h1;
            sync_good <= 2'h0;
          end else if (sync_good != SRX_GOOD_LAST) begin
            sync_good <= sync_good + 2'h1;
          end
        end
        default: sync_st <= srx_los;
      endcase
    end
  end

  // word and its status registered together
  always_ff @(posedge rx_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      word_out <= '0;
    end else begin
      word_out.valid <= strobe;
      if (strobe) begin
        // 8-bit path keeps upper bits at zero
        word_out.data    <= WIDTH10 ? cur[9:0] : {2'h0, cur[7:0]};
        // detector flags the pattern in every mode
        word_out.pat_det <= cur_hit;
        word_out.aligned <= (ALIGN_MODE == srx_xaui_align ||
                             ALIGN_MODE == srx_gigabit_ethernet_mode_align) ?
                            (sync_st == srx_synced) :
                            (locked || realign_now);
        word_out.run_err <= run_flag || run_now;
      end
    end
  end

  override_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    chan_used && ovr_data |=> cru_stat.vco_track_data)
    else $error("data override not obeyed");

  override_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovr_ref |=> !cru_stat.vco_track_data)
    else $error("reference override not obeyed");

  auto_default_a: assert property (@(posedge clk) disable iff (!rst_n)
    !OVERRIDE_USED && !auto_data ##1 !auto_data
    |=> !cru_stat.vco_track_data)
    else $error("override inputs acted while unused");

  auto_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(auto_data) |-> $past(match_ok))
    else $error("switchover without ppm and phase match");

  pll_lock_n_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cru_stat.pll_locked_n |-> $past(pll_lock_raw, 3))
    else $error("lock reported without PLL lock");

  power_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    !chan_used |=> cru_stat.pll_pd && cru_stat.cru_pd &&
                   !cru_stat.data_locked)
    else $error("unused channel not powered down");

  slip_step_a: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    ALIGN_MODE == srx_bitslip && active && slip_rise
    |=> off == (($past(off) == W_LAST) ? 4'h0 : $past(off) + 4'h1))
    else $error("slip did not move boundary by one bit");

  enable_gate_a: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    strobe && bit_cnt != W_LAST
    |-> ALIGN_MODE != srx_pat10 || align_enable)
    else $error("10-bit alignment while enable low");

  pat_lock_a: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    ALIGN_MODE == srx_pat16 && $rose(locked) |-> $past(head_hit))
    else $error("16-bit lock without pattern");

  // Next word leaves within one word time plus the output register
  run_err_a: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    active && run_now
    |-> ##[1:10] (word_out.valid && word_out.run_err))
    else $error("run-length violation not reported");

  sync_loss_a: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    active && strobe && sync_st == srx_synced &&
    sync_err == SRX_ERR_LAST && !word_ok |=> sync_st == srx_los)
    else $error("sync not lost after error limit");

  track_data_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(cru_stat.data_locked));
  slip_c: cover property (@(posedge rx_clk) disable iff (!lrst_n)
    active && slip_rise ##[1:20] word_out.valid);
  sync_c: cover property (@(posedge rx_clk) disable iff (!lrst_n)
    sync_st == srx_detect ##[1:100] sync_st == srx_synced);
  pat_det_c: cover property (@(posedge rx_clk) disable iff (!lrst_n)
    word_out.valid && word_out.pat_det && word_out.aligned);

endmodule
`default_nettype wire

// file: tb/srx_serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
module srx_serial_tx (
  input  wire logic rx_clk,
  input  wire logic rst_n,
  output logic      serial_in
);
  import srx_pkg::*;
  bit q[$];

  task automatic send(input logic [9:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      q.push_back(w[i]);
    end
  endtask

  // first bit out is LSB
  // Idle fills whole alternating words so framing stays known
  always @(posedge rx_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_in <= 1'b0;
    end else begin
      if (q.size() == 0) begin
        send(10'h155, 10);
      end
      serial_in <= q.pop_front();
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srx_pkg::*;
  logic         clk             = 1'b0;
  logic         rx_clk          = 1'b0;
  logic         rst_n           = 1'b0;
  logic         chan_used       = 1'b0;
  logic         force_data_lock = 1'b0;
  logic         force_ref_lock  = 1'b0;
  logic         pll_lock_raw    = 1'b0;
  logic [10:0]  ppm_diff        = 11'h7ff;
  logic [6:0]   phase_err       = 7'h00;
  logic         slip_req        = 1'b0;
  logic         realign_req     = 1'b0;
  logic         align_enable    = 1'b0;
  wire  logic   serial_in;
  srx_cru_type  cru_stat;
  srx_word_type word_out;
  logic         cfg_error;
  logic [11:0]  rxq[$];
  int           n_mismatch      = 0;
  int           cmp_count       = 0;
  bit           auto_st         = 1'b0;
  bit           seen_run        = 1'b0;

  always #20 clk = ~clk;
  always #16 rx_clk = ~rx_clk;

  srx_top #(
    .PROTOCOL     (srx_custom),
    .ALIGN_MODE   (srx_pat10),
    .WIDTH10      (1'b1),
    .OVERRIDE_USED(1'b1),
    .RUN_LIMIT    (SRX_RUN_MAX10),
    .PATTERN      (32'h0000017c)
  ) uut (
    .clk            (clk),
    .rst_n          (rst_n),
    .chan_used      (chan_used),
    .force_data_lock(force_data_lock),
    .force_ref_lock (force_ref_lock),
    .pll_lock_raw   (pll_lock_raw),
    .ppm_diff       (ppm_diff),
    .phase_err      (phase_err),
    .cru_stat       (cru_stat),
    .rx_clk         (rx_clk),
    .serial_in      (serial_in),
    .slip_req       (slip_req),
    .realign_req    (realign_req),
    .align_enable   (align_enable),
    .word_out       (word_out),
    .cfg_error      (cfg_error)
  );

  srx_serial_tx tx (
    .rx_clk   (rx_clk),
    .rst_n    (rst_n),
    .serial_in(serial_in)
  );

  always @(posedge rx_clk) begin
    if (word_out.valid === 1'b1) begin
      rxq.push_back({word_out.data, word_out.aligned, word_out.pat_det});
    end
    if (word_out.valid === 1'b1 && word_out.run_err === 1'b1) begin
      seen_run = 1'b1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reference lock and power control, modelled with the auto state
  task automatic clock_recovery_unit(input bit u, fd, fr, raw, input int ppm, ph);
    bit trk;
    @(posedge clk);
    chan_used <= u;
    force_data_lock <= fd;
    force_ref_lock <= fr;
    pll_lock_raw <= raw;
    ppm_diff <= 11'(ppm);
    phase_err <= 7'(ph);
    auto_st = auto_st ? ppm <= 125 : (ppm <= 125 && ph <= 8);
    trk = u && (fd || (!fr && auto_st));
    repeat (4) @(posedge clk);
    #1;
    chk(16'(cru_stat), 16'({trk, !(raw && u), trk, !u, !u}));
  endtask

  // No 5-long runs, so commas appear only where placed
  function automatic logic [9:0] spread(input logic [4:0] r);
    for (int i = 0; i < 5; i++) begin
      spread[2*i] = r[i];
      spread[2*i+1] = ~r[i];
    end
  endfunction

  task automatic run(input logic [9:0] pat, pre, input int npre, bit hit);
    logic [9:0] ex[$];
    logic [9:0] r;
    int         k;
    @(posedge rx_clk);
    rxq.delete();
    slip_req <= ~slip_req;
    realign_req <= ~realign_req;
    tx.send(pre, npre);
    tx.send(pat, 10);
    for (int i = 0; i < 4; i++) begin
      r = spread(5'($urandom));
      ex.push_back(r);
      tx.send(r, 10);
    end
    repeat (150) @(posedge rx_clk);
    k = 0;
    while (k < rxq.size() && rxq[k][11:2] !== pat) begin
      k++;
    end
    if (!hit) begin
      chk(16'(k), 16'(rxq.size()));
      return;
    end
    chk(16'(rxq.size() > k + 4), 16'h0001);
    if (rxq.size() > k + 4) begin
      chk(16'(rxq[k]), 16'({pat, 2'b11}));
      for (int i = 0; i < 4; i++) begin
        chk(16'(rxq[k+1+i]), 16'({ex[i], 2'b10}));
      end
    end
  endtask

  // Idle ends in 0 and restarts with 1, so the zero run is n plus one bits
  task automatic long_run(input int n, input bit want);
    @(posedge rx_clk);
    seen_run = 1'b0;
    for (int i = 0; i < n; i += 10) begin
      tx.send(10'h000, (n - i < 10) ? n - i : 10);
    end
    repeat (250) @(posedge rx_clk);
    chk(16'(seen_run), 16'(want));
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    void'($urandom(77));
    repeat (3) @(posedge clk);
    chk(16'(cru_stat), 16'(SRX_CRU_RESET));
    chk(16'(word_out), 16'h0000);
    rst_n <= 1'b1;
    clock_recovery_unit(0, 0, 0, 1, 2000, 0);
    for (int i = 0; i < 4; i++) begin
      clock_recovery_unit(1, i[1], i[0], 1, 2000, 0);
    end
    clock_recovery_unit(1, 0, 1, 1, 0, 0);
    clock_recovery_unit(1, 0, 0, 1, 2000, 0);
    clock_recovery_unit(1, 0, 0, 1, 0, 9);
    clock_recovery_unit(1, 0, 0, 1, 125, 8);
    clock_recovery_unit(1, 0, 0, 0, 126, 0);
    repeat (30) begin
      clock_recovery_unit(1, 0, 0, 1'($urandom), $urandom_range(140, 110),
          $urandom_range(12, 4));
    end
    clock_recovery_unit(1, 1, 0, 1, 2000, 0);
    chk(16'(cfg_error), 16'h0000);
    @(posedge rx_clk);
    align_enable <= 1'b1;
    repeat (20) @(posedge rx_clk);
    // Slip and realign toggles must be ignored in this mode
    run(SRX_COMMA_NEG, 10'h000, 0, 1'b1);
    run(SRX_COMMA_POS, 10'h005, 3, 1'b1);
    @(posedge rx_clk);
    align_enable <= 1'b0;
    run(SRX_COMMA_NEG, 10'h015, 5, 1'b0);
    @(posedge rx_clk);
    align_enable <= 1'b1;
    run(SRX_COMMA_NEG, 10'h015, 5, 1'b1);
    // A run equal to the limit passes, one bit more is flagged
    long_run(SRX_RUN_MAX10 - 1, 1'b0);
    long_run(SRX_RUN_MAX10, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
